//--- rtl/ulad_addr_gen.sv
// Source and destination address generator for one array move
module ulad_addr_gen (
   input  wire logic [2:0]                    link,         // Link being served
   input  wire logic [4:0]                    middle_idx,   // Stream array index
   input  wire logic [6:0]                    frame_idx,    // Outer frame index
   input  wire logic [31:0]                   dst_base,     // Active destination base
   output logic      [ulad_pkg::SRC_AW-1:0]   src_addr,     // Inbound RAM byte address
   output logic      [31:0]                   dst_addr      // Local memory byte address
);
   logic [31:0] src_full;
   logic [31:0] frame_wrapped;

   // Source wraps inside the 32-chip region so one descriptor covers the whole buffer
   always_comb
   begin
      frame_wrapped = 32'(frame_idx) % 32'(ulad_pkg::REGION_FRAMES);
      src_full = 32'(link) * 32'(ulad_pkg::LINK_SPAN)
               + frame_wrapped * 32'(ulad_pkg::SRC_OUTER_STEP)
               + 32'(middle_idx) * 32'(ulad_pkg::SRC_MIDDLE_STEP);
      src_addr = src_full[ulad_pkg::SRC_AW-1:0];
      dst_addr = dst_base
               + 32'(middle_idx) * 32'(ulad_pkg::DST_MIDDLE_STEP)
               + 32'(frame_idx) * 32'(ulad_pkg::DST_OUTER_STEP);
   end
endmodule

//--- rtl/ulad_dma.sv
// Uplink antenna transfer engine: inbound sample RAM to processor local memory
// How it works
// - Each eight-chip tick moves all streams of its own link, or of every enabled link with chaining
// - Four contiguous 256-chip buffers per stream
// - Eight-bit I and Q, two bytes per chip
// - Source region holds 32 chips per stream
// - Sixteen streams per link, six links maximum
// - Over-sampling by two doubles stream arrays
// - 16-byte arrays, middle 2xcarriers, outer 128
// - Source steps 16 middle, 512 outer
// - Destination steps 2048 middle, 16 outer
// - One tick launches whole two-dimensional block
// - Finished link chains to next link
// - Control transfer: two 16-byte words, outer 8
// - Link source addresses wrap within 32-chip region
module ulad_dma #(
   parameter int DW = 128  // Data word width, one 16-byte array
) (
   input  wire logic                          pclk,          // System clock
   input  wire logic                          presetn,       // Asynchronous reset, active low
   input  wire logic                          psel,          // APB select
   input  wire logic                          penable,       // APB access phase
   input  wire logic                          pwrite,        // APB write
   input  wire logic [11:0]                   paddr,         // APB byte address
   input  wire logic [31:0]                   pwdata,        // APB write data
   output logic      [31:0]                   prdata,        // APB read data
   output logic                               pready,        // APB ready
   output logic                               pslverr,       // APB error on unmapped address
   input  wire logic [ulad_pkg::MAX_LINKS-1:0] link_tick,    // Per-link eight-chip tick pulses
   output logic                               src_rd_en,     // Inbound RAM read strobe
   output logic      [ulad_pkg::SRC_AW-1:0]   src_rd_addr,   // Inbound RAM byte address
   input  wire logic [DW-1:0]                 src_rd_data,   // Read data, one cycle after strobe
   output logic                               dst_wr_valid,  // Local memory write request
   output logic      [31:0]                   dst_wr_addr,   // Local memory byte address
   output logic      [DW-1:0]                 dst_wr_data,   // Local memory write data
   input  wire logic                          dst_wr_ready,  // Local memory accepts write
   output logic      [ulad_pkg::MAX_LINKS-1:0] link_done     // Pulse when a link's block is written
);
   localparam int NL = ulad_pkg::MAX_LINKS;

   // Register state
   logic [NL-1:0]              link_en_q;
   logic                       chain_en_q;
   logic [ulad_pkg::SRC_AW-1:0] ps_src_q;
   logic [31:0]                ps_dst_q;
   logic [31:0]                dst_active_q [NL];
   logic [31:0]                reload_q     [NL];
   logic [4:0]                 carriers_q   [NL];
   logic [6:0]                 frame_q      [NL];
   // Engine state
   ulad_pkg::ulad_state_type   state_q;
   logic [NL-1:0]              pending_q;
   logic                       ps_pending_q;
   logic [2:0]                 cur_link_q;
   logic                       is_ps_q;
   logic [4:0]                 mid_q;
   logic [2:0]                 ps_frame_q;
   logic                       ps_word_q;
   // Bus strobes and combinational engine decode
   logic                       wr_acc;
   logic                       setup;
   logic [NL-1:0]              tick_set;
   logic [NL-1:0]              done_clr;
   logic                       ps_trig;
   logic                       ps_done;
   logic [ulad_pkg::SRC_AW-1:0] gen_src;
   logic [31:0]                gen_dst;
   logic [4:0]                 mid_last;
   logic [2:0]                 pick;
   logic                       link_finish;

   // Lowest pending link wins; chaining walks upward from there
   function automatic logic [2:0] first_one(input logic [NL-1:0] v);
      first_one = 3'h0;
      for (int i = NL - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            first_one = 3'(i);
         end
      end
   endfunction

   // Address decode shared by read and write: link index, or 7 for none
   function automatic logic [2:0] link_of(input logic [11:0] a);
      link_of = 3'h7;
      for (int i = 0; i < NL; i++)
      begin
         if (a[11:4] == 8'((ulad_pkg::REG_LINK0 + 12'(i) * ulad_pkg::LINK_STRIDE) >> 4))
         begin
            link_of = 3'(i);
         end
      end
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == ulad_pkg::REG_CTRL) || (a == ulad_pkg::REG_STATUS) ||
               (a == ulad_pkg::REG_PS_SRC) || (a == ulad_pkg::REG_PS_DST) ||
               (a == ulad_pkg::REG_PS_TRIG) ||
               ((link_of(a) != 3'h7) && (a[3:0] != 4'h0) && (a[1:0] == 2'b00));
   endfunction

   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pwrite && pready && !pslverr;
   assign ps_trig = wr_acc && (paddr == ulad_pkg::REG_PS_TRIG) && pwdata[0];

   // Middle count is twice the carrier count, one array per over-sampled stream
   assign mid_last = is_ps_q ? 5'(ulad_pkg::PS_MIDDLE_COUNT - 1)
                             : 5'(carriers_q[cur_link_q] * 5'(ulad_pkg::OVERSAMPLE) - 5'h01);
   assign pick = first_one(pending_q);
   assign link_finish = (state_q == ulad_pkg::ST_WRITE) && dst_wr_ready && !is_ps_q && (mid_q == mid_last);
   assign ps_done = (state_q == ulad_pkg::ST_WRITE) && dst_wr_ready && is_ps_q && ps_word_q;

   ulad_addr_gen u_addr (
      .link       (cur_link_q),
      .middle_idx (mid_q),
      .frame_idx  (frame_q[cur_link_q]),
      .dst_base   (dst_active_q[cur_link_q]),
      .src_addr   (gen_src),
      .dst_addr   (gen_dst)
   );

   // APB answer: ready in every access phase, error for holes in the map
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup && !mapped(paddr);
         prdata  <= 32'h0000_0000;
         if (setup && !pwrite)
         begin
            if (paddr == ulad_pkg::REG_CTRL)
               prdata <= 32'(link_en_q) | (32'(chain_en_q) << ulad_pkg::CTRL_CHAIN_BIT);
            else if (paddr == ulad_pkg::REG_STATUS)
               prdata <= 32'(pending_q) | (32'(ps_pending_q) << ulad_pkg::ST_PS_BIT)
                       | (32'(state_q != ulad_pkg::ST_IDLE) << ulad_pkg::ST_BUSY_BIT);
            else if (paddr == ulad_pkg::REG_PS_SRC)
               prdata <= 32'(ps_src_q);
            else if (paddr == ulad_pkg::REG_PS_DST)
               prdata <= ps_dst_q;
            else if (link_of(paddr) != 3'h7)
            begin
               case (paddr[3:0])
                  ulad_pkg::LREG_DST:     prdata <= dst_active_q[link_of(paddr)];
                  ulad_pkg::LREG_RELOAD:  prdata <= reload_q[link_of(paddr)];
                  ulad_pkg::LREG_CARRIER: prdata <= 32'(carriers_q[link_of(paddr)])
                     | (32'(frame_q[link_of(paddr)]) << ulad_pkg::LC_FRAME_LSB)
                     // Buffer now being filled; the other three belong to the processor
                     | (32'(frame_q[link_of(paddr)][6:5]) << ulad_pkg::LC_BUF_LSB);
                  default:                prdata <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   // Global control and packet-switched descriptor
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         link_en_q  <= NL'(ulad_pkg::CTRL_RST);
         chain_en_q <= 1'b0;
         ps_src_q   <= ulad_pkg::SRC_AW'(ulad_pkg::ADDR_RST);
         ps_dst_q   <= ulad_pkg::ADDR_RST;
      end
      else if (wr_acc)
      begin
         if (paddr == ulad_pkg::REG_CTRL)
         begin
            link_en_q  <= pwdata[NL-1:0];
            chain_en_q <= pwdata[ulad_pkg::CTRL_CHAIN_BIT];
         end
         if (paddr == ulad_pkg::REG_PS_SRC)
            ps_src_q <= pwdata[ulad_pkg::SRC_AW-1:0];
         if (paddr == ulad_pkg::REG_PS_DST)
            ps_dst_q <= pwdata;
      end
   end

   // Per-link descriptors; a written base restarts the frame count
   generate
      for (genvar l = 0; l < NL; l++)
      begin : g_link
         logic sel;
         assign sel = wr_acc && (link_of(paddr) == 3'(l));
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               dst_active_q[l] <= ulad_pkg::ADDR_RST;
               reload_q[l]     <= ulad_pkg::ADDR_RST;
               carriers_q[l]   <= ulad_pkg::CARR_RST;
               frame_q[l]      <= 7'h00;
            end
            else if (sel && paddr[3:0] == ulad_pkg::LREG_DST)
            begin
               dst_active_q[l] <= pwdata;
               frame_q[l]      <= 7'h00;
            end
            else if (sel && paddr[3:0] == ulad_pkg::LREG_RELOAD)
               reload_q[l] <= pwdata;
            else if (sel && paddr[3:0] == ulad_pkg::LREG_CARRIER)
               // More than sixteen carriers cannot fit the link's region
               carriers_q[l] <= (pwdata[4:0] > 5'(ulad_pkg::STREAMS_PER_LINK))
                              ? 5'(ulad_pkg::STREAMS_PER_LINK) : pwdata[4:0];
            else if (done_clr[l])
            begin
               if (frame_q[l] == 7'(ulad_pkg::OUTER_FRAMES - 1))
               begin
                  frame_q[l]      <= 7'h00;
                  dst_active_q[l] <= reload_q[l];
               end
               else
                  frame_q[l] <= frame_q[l] + 7'h01;
            end
         end
      end
   endgenerate

   // Tick capture: with chaining, a tick on any enabled link triggers every enabled link
   always_comb
   begin
      tick_set = '0;
      for (int i = 0; i < NL; i++)
      begin
         if (link_tick[i] && link_en_q[i])
            tick_set = tick_set | (chain_en_q ? link_en_q : NL'(1) << i);
      end
   end

   // A tick arriving as its link finishes is kept, since set beats clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pending_q    <= '0;
         ps_pending_q <= 1'b0;
      end
      else
      begin
         pending_q    <= (pending_q & ~done_clr) | tick_set;
         ps_pending_q <= (ps_pending_q && !ps_done) || ps_trig;
      end
   end

   // Link finishes after the last array, or at once when it has no carriers
   always_comb
   begin
      done_clr = '0;
      if (link_finish || ((state_q == ulad_pkg::ST_IDLE) && (pending_q != '0) && (carriers_q[pick] == 5'h00)))
         done_clr[link_finish ? cur_link_q : pick] = 1'b1;
   end

   // Engine: read one array, write it, step middle index until the block is done
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q      <= ulad_pkg::ST_IDLE;
         cur_link_q   <= 3'h0;
         is_ps_q      <= 1'b0;
         mid_q        <= 5'h00;
         ps_frame_q   <= 3'h0;
         ps_word_q    <= 1'b0;
         src_rd_en    <= 1'b0;
         src_rd_addr  <= '0;
         dst_wr_valid <= 1'b0;
         dst_wr_addr  <= 32'h0000_0000;
         dst_wr_data  <= '0;
         link_done    <= '0;
      end
      else
      begin
         src_rd_en <= 1'b0;
         link_done <= done_clr;
         case (state_q)
            ulad_pkg::ST_IDLE:
            begin
               mid_q     <= 5'h00;
               ps_word_q <= 1'b0;
               if ((pending_q != '0) && (carriers_q[pick] != 5'h00))
               begin
                  cur_link_q <= pick;
                  is_ps_q    <= 1'b0;
                  state_q    <= ulad_pkg::ST_READ;
               end
               else if ((pending_q == '0) && ps_pending_q)
               begin
                  is_ps_q <= 1'b1;
                  state_q <= ulad_pkg::ST_READ;
               end
            end
            ulad_pkg::ST_READ:
            begin
               // Control words come from a FIFO port, so the source address holds
               src_rd_en   <= 1'b1;
               src_rd_addr <= is_ps_q ? ps_src_q : gen_src;
               state_q     <= ulad_pkg::ST_LAT;
            end
            ulad_pkg::ST_LAT:
               state_q <= ulad_pkg::ST_DATA;
            ulad_pkg::ST_DATA:
            begin
               // Each 16-byte link word is eight chips of byte-wide I and Q; control words pass through unchanged
               dst_wr_data  <= src_rd_data;
               dst_wr_addr  <= is_ps_q ? ps_dst_q + 32'(ps_frame_q) * 32'(ulad_pkg::PS_ARRAY_BYTES)
                                                  + 32'(ps_word_q) * 32'(ulad_pkg::ARRAY_BYTES)
                                       : gen_dst;
               dst_wr_valid <= 1'b1;
               state_q      <= ulad_pkg::ST_WRITE;
            end
            ulad_pkg::ST_WRITE:
            begin
               if (dst_wr_ready)
               begin
                  dst_wr_valid <= 1'b0;
                  if (is_ps_q)
                  begin
                     ps_word_q <= !ps_word_q;
                     if (ps_word_q)
                     begin
                        ps_frame_q <= (ps_frame_q == 3'(ulad_pkg::PS_OUTER_COUNT - 1))
                                    ? 3'h0 : ps_frame_q + 3'h1;
                        state_q    <= ulad_pkg::ST_IDLE;
                     end
                     else
                        state_q <= ulad_pkg::ST_READ;
                  end
                  else if (mid_q != mid_last)
                  begin
                     // Whole block runs on one trigger
                     mid_q   <= mid_q + 5'h01;
                     state_q <= ulad_pkg::ST_READ;
                  end
                  else
                     state_q <= ulad_pkg::ST_IDLE;
               end
            end
            default:
               state_q <= ulad_pkg::ST_IDLE;
         endcase
      end
   end
endmodule

//--- rtl/ulad_pkg.sv
// Constants and types shared by the uplink antenna transfer engine
package ulad_pkg;
   // Memory geometry
   localparam int MAX_LINKS         = 6;     // Links served by the inbound RAM
   localparam int STREAMS_PER_LINK  = 16;    // Antenna carriers per link
   localparam int OVERSAMPLE        = 2;     // Over-sampling factor, the only one supported
   localparam int BYTES_PER_CHIP    = 2;     // 8-bit I plus 8-bit Q
   localparam int CHIPS_PER_TICK    = 8;     // Chips moved per stream per tick
   localparam int ARRAY_BYTES       = CHIPS_PER_TICK * BYTES_PER_CHIP;
   localparam int REGION_CHIPS      = 32;    // Circular source depth per stream
   localparam int BUF_CHIPS         = 256;   // Chips per destination buffer
   localparam int BUFS_PER_STREAM   = 4;     // Destination buffers per stream
   localparam int OUTER_FRAMES      = BUF_CHIPS * BUFS_PER_STREAM / CHIPS_PER_TICK;
   localparam int REGION_FRAMES     = REGION_CHIPS / CHIPS_PER_TICK;
   localparam int FRAMES_PER_BUF    = BUF_CHIPS / CHIPS_PER_TICK;
   // Address steps in bytes
   localparam int SRC_MIDDLE_STEP   = 16;
   localparam int SRC_OUTER_STEP    = 512;
   localparam int DST_MIDDLE_STEP   = 2048;
   localparam int DST_OUTER_STEP    = 16;
   localparam int LINK_SPAN         = SRC_OUTER_STEP * REGION_FRAMES;
   localparam int SRC_AW            = 14;    // Byte address into 12288-byte inbound RAM
   // Packet-switched control transfer
   localparam int PS_ARRAY_BYTES    = 32;    // 19 control bytes then 13 zero bytes
   localparam int PS_WORDS          = PS_ARRAY_BYTES / ARRAY_BYTES;
   localparam int PS_MIDDLE_COUNT   = 1;
   localparam int PS_OUTER_COUNT    = 8;
   // Register byte offsets
   localparam logic [11:0] REG_CTRL     = 12'h000;
   localparam logic [11:0] REG_STATUS   = 12'h004;
   localparam logic [11:0] REG_PS_SRC   = 12'h008;
   localparam logic [11:0] REG_PS_DST   = 12'h00C;
   localparam logic [11:0] REG_PS_TRIG  = 12'h010;
   localparam logic [11:0] REG_LINK0    = 12'h040;  // First link block
   localparam logic [11:0] LINK_STRIDE  = 12'h010;
   localparam logic [3:0]  LREG_DST     = 4'h4;     // Active destination base
   localparam logic [3:0]  LREG_RELOAD  = 4'h8;     // Reload destination base
   localparam logic [3:0]  LREG_CARRIER = 4'hC;     // Carrier count and progress
   // Field positions
   localparam int CTRL_CHAIN_BIT    = 8;
   localparam int ST_PS_BIT         = 6;
   localparam int ST_BUSY_BIT       = 8;
   localparam int LC_FRAME_LSB      = 8;
   localparam int LC_BUF_LSB        = 16;
   // Reset values
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] ADDR_RST   = 32'h0000_0000;
   localparam logic [4:0]  CARR_RST   = 5'h00;

   typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_LAT, ST_DATA, ST_WRITE} ulad_state_type;
endpackage

//--- testbench/ulad_dma_properties.sv
// Port-level checker for the uplink antenna transfer engine
module ulad_chk_props #(
   parameter int DW = 128  // Data word width
) (
   input wire logic         pclk,          // Clock
   input wire logic         presetn,       // Reset, active low
   input wire logic         psel,          // APB select
   input wire logic         penable,       // APB enable
   input wire logic [31:0]  prdata,        // APB read data
   input wire logic         pready,        // APB ready
   input wire logic         pslverr,       // APB error
   input wire logic         src_rd_en,     // RAM read strobe
   input wire logic [13:0]  src_rd_addr,   // RAM address
   input wire logic [DW-1:0] src_rd_data,  // RAM data
   input wire logic         dst_wr_valid,  // Write request
   input wire logic [31:0]  dst_wr_addr,   // Write address
   input wire logic [DW-1:0] dst_wr_data,  // Write data
   input wire logic         dst_wr_ready,  // Write accept
   input wire logic [5:0]   link_done      // Link done pulses
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_apb_answer; psel && !penable |=> pready; endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("No ready after setup cycle");
   property p_ready_access; pready |-> psel && penable; endproperty
   a_ready_access: assert property (p_ready_access) else $error("Ready outside access phase");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("Error without ready");
   property p_rdata_idle; !pready |-> prdata == 32'h0000_0000; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("Read data not zero when idle");
   property p_rd_pulse; src_rd_en |=> !src_rd_en; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("Read strobe longer than one cycle");
   property p_rd_to_wr; src_rd_en |-> ##2 (dst_wr_valid && dst_wr_data == $past(src_rd_data)); endproperty
   a_rd_to_wr: assert property (p_rd_to_wr) else $error("Read data not forwarded to write");
   property p_src_bounds; src_rd_en |-> src_rd_addr[3:0] == 4'h0 && src_rd_addr < 14'h3000; endproperty
   a_src_bounds: assert property (p_src_bounds) else $error("Source address outside RAM");
   property p_wr_hold; dst_wr_valid && !dst_wr_ready |=> dst_wr_valid && $stable(dst_wr_addr)
      && $stable(dst_wr_data); endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("Write request dropped while stalled");
   property p_done_one; $onehot0(link_done); endproperty
   a_done_one: assert property (p_done_one) else $error("Two links done at once");
endmodule

bind ulad_dma ulad_chk_props #(.DW(DW)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_rd_en(src_rd_en), .src_rd_addr(src_rd_addr),
   .src_rd_data(src_rd_data), .dst_wr_valid(dst_wr_valid), .dst_wr_addr(dst_wr_addr),
   .dst_wr_data(dst_wr_data), .dst_wr_ready(dst_wr_ready), .link_done(link_done));

//--- testbench/ulad_dma_tb.sv
// Self-checking testbench for the uplink antenna transfer engine
module uplink_antenna_dma_transfer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic [11:0]  paddr = 12'h000;
   logic [31:0]  pwdata = 32'h0000_0000, prdata, dst_wr_addr, rq;
   logic         pready, pslverr, src_rd_en, dst_wr_valid, dst_wr_ready, re;
   logic [5:0]   link_tick = 6'h00, link_done;
   logic [13:0]  src_rd_addr;
   logic [127:0] src_rd_data, dst_wr_data;
   logic [31:0]  exp_a[$], base[3], rel[3];
   logic [127:0] exp_d[$];
   int           num_errors = 0, checked = 0, frm[3], car[3], dones[3] = '{0, 0, 0};
   always #10 pclk = ~pclk;
   ulad_dma i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_tick(link_tick), .src_rd_en(src_rd_en), .src_rd_addr(src_rd_addr), .src_rd_data(src_rd_data),
      .dst_wr_valid(dst_wr_valid), .dst_wr_addr(dst_wr_addr), .dst_wr_data(dst_wr_data),
      .dst_wr_ready(dst_wr_ready), .link_done(link_done));
   ulad_far_model i_far (.pclk(pclk), .presetn(presetn), .slow(slow), .src_rd_en(src_rd_en),
      .src_rd_addr(src_rd_addr), .src_rd_data(src_rd_data), .dst_wr_ready(dst_wr_ready));
   task report_and_stop;
      if (num_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input bit ok, input string msg);
      checked++;
      if (!ok)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   function logic [127:0] pat(input logic [13:0] a);
      return {8{2'b10, a}};
   endfunction
   function logic [11:0] la(input int l, input logic [3:0] o);
      return 12'(ulad_pkg::REG_LINK0 + ulad_pkg::LINK_STRIDE * l + o);
   endfunction
   // APB transfer; the request is held until ready is sampled high
   task apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rq === e && re === 1'b0, "register read value");
   endtask
   // Expected writes of one link block; frame wraps after 128 and the reload base takes over
   task push_link(input int l);
      for (int m = 0; m < 2 * car[l]; m++)
      begin
         exp_a.push_back(base[l] + 32'(m * 2048 + frm[l] * 16));
         exp_d.push_back(pat(14'(l * 2048 + (frm[l] % 4) * 512 + m * 16)));
      end
      frm[l] = (frm[l] + 1) % 128;
      if (frm[l] == 0) base[l] = rel[l];
   endtask
   // Bounded wait until every expected write has been seen
   task drain;
      int n;
      n = 0;
      while (exp_a.size() != 0 && n++ < 4000) @(posedge pclk);
      chk(exp_a.size() == 0, "transfer did not complete");
      repeat (6) @(posedge pclk);
   endtask
   // Stand-in for the tick generator; its 10 ms frame tick only paces the MACs
   task tick(input logic [5:0] v);
      @(posedge pclk);
      link_tick <= v;
      @(posedge pclk);
      link_tick <= 6'h00;
      drain;
   endtask
   // Scoreboard on accepted writes, plus done-pulse counting
   always @(posedge pclk)
   begin
      if (dst_wr_valid === 1'b1 && dst_wr_ready === 1'b1)
      begin
         chk(exp_a.size() != 0 && dst_wr_addr === exp_a[0] && dst_wr_data === exp_d[0], "write mismatch");
         if (exp_a.size() != 0) void'(exp_a.pop_front());
         if (exp_d.size() != 0) void'(exp_d.pop_front());
      end
      for (int l = 0; l < 3; l++) if (link_done[l] === 1'b1) dones[l]++;
   end
   // Main sequence: reset values, unmapped access, link traffic with wrap, control transfers
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(ulad_pkg::REG_CTRL, ulad_pkg::CTRL_RST);
      rd_chk(la(0, ulad_pkg::LREG_CARRIER), 32'h0000_0000);
      apb(1'b1, 12'h040, 32'hFFFF_FFFF);
      chk(re === 1'b1, "unmapped write not refused");
      apb(1'b0, 12'h040, 32'h0000_0000);
      chk(re === 1'b1 && rq === 32'h0000_0000, "unmapped read not refused");
      for (int l = 0; l < 3; l++)
      begin
         base[l] = 32'h1000_0000 * (2 * l + 1);
         rel[l] = 32'h1000_0000 * (2 * l + 2);
         car[l] = (l == 0) ? 2 : 1;
         frm[l] = 0;
         apb(1'b1, la(l, ulad_pkg::LREG_DST), base[l]);
         apb(1'b1, la(l, ulad_pkg::LREG_RELOAD), rel[l]);
         apb(1'b1, la(l, ulad_pkg::LREG_CARRIER), 32'h0000_001F);
         rd_chk(la(l, ulad_pkg::LREG_CARRIER), 32'h0000_0010);
         apb(1'b1, la(l, ulad_pkg::LREG_CARRIER), 32'(car[l]));
      end
      apb(1'b1, ulad_pkg::REG_CTRL, 32'h0000_0103);
      // Link 2 stays disabled, so its tick must move nothing; chaining serves links 0 and 1
      for (int t = 0; t < 130; t++)
      begin
         slow <= t[0];
         push_link(0);
         push_link(1);
         tick(t[0] ? 6'h06 : 6'h01);
         if (t == 39) apb(1'b0, la(0, ulad_pkg::LREG_CARRIER), 32'h0000_0000);
         if (t == 39) chk(rq[14:8] === 7'h28 && rq[17:16] === 2'h1, "frame or fill buffer");
      end
      apb(1'b1, ulad_pkg::REG_PS_SRC, 32'h0000_0120);
      apb(1'b1, ulad_pkg::REG_PS_DST, 32'h7000_0000);
      for (int f = 0; f < 2; f++)
      begin
         for (int w = 0; w < 2; w++) exp_a.push_back(32'h7000_0000 + 32'(f * 32 + w * 16));
         for (int w = 0; w < 2; w++) exp_d.push_back(pat(14'h0120));
         apb(1'b1, ulad_pkg::REG_PS_TRIG, 32'h0000_0001);
         drain;
      end
      // Chaining off: only link 1 moves
      apb(1'b1, ulad_pkg::REG_CTRL, 32'h0000_0003);
      push_link(1);
      tick(6'h02);
      rd_chk(ulad_pkg::REG_STATUS, 32'h0000_0000);
      chk(dones[0] == 130 && dones[1] == 131 && dones[2] == 0, "link done count");
      report_and_stop;
   end
   // Watchdog well beyond the expected run length
   initial
   begin
      #1_000_000;
      chk(1'b0, "watchdog expired");
      report_and_stop;
   end
endmodule

//--- testbench/ulad_far_model.sv
// Far-side model: inbound sample RAM with one-cycle read latency and a local memory that can stall
module ulad_far_model (
   input  wire logic         pclk,          // System clock
   input  wire logic         presetn,       // Asynchronous reset, active low
   input  wire logic         slow,          // Drop write ready every other cycle when high
   input  wire logic         src_rd_en,     // Read strobe from the engine
   input  wire logic [13:0]  src_rd_addr,   // Read byte address
   output logic      [127:0] src_rd_data,   // Read data, valid one cycle after strobe
   output logic              dst_wr_ready   // Write acceptance
);
   logic rd_q;
   logic tgl_q;
   // Latency and stall pacing state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_q  <= 1'b0;
         tgl_q <= 1'b0;
      end
      else
      begin
         rd_q  <= src_rd_en;
         tgl_q <= ~tgl_q;
      end
   end
   // Two bytes a chip; outside the data cycle the bus shows the inverse so stale reads cannot match
   assign src_rd_data  = rd_q ? {8{2'b10, src_rd_addr}} : ~{8{2'b10, src_rd_addr}};
   assign dst_wr_ready = !slow || tgl_q;
endmodule
